// [design/sra_map.svh]
`ifndef SRA_MAP_SVH
`define SRA_MAP_SVH

// Slave address for select pins 00; pins 01, 10 and 11 add one, two and three.
`define SRA_ADDR_BASE     7'h4C
// Register index that is never acknowledged.
`define SRA_NOACK_INDEX   8'h0F
// Pointer value after reset.
`define SRA_PTR_RESET     8'h00
// Data bits in a byte; the acknowledge slot follows as the ninth pulse.
`define SRA_BITS_PER_BYTE 4'h8
// Host clock period and serial clock period, in nanoseconds.
`define SRA_SYS_CLK_NS    25
`define SRA_SCL_PERIOD_NS 10000
// Cycles of the host clock per quarter of a serial clock period.
`define SRA_QTR_CYCLES    ((`SRA_SCL_PERIOD_NS / 4) / `SRA_SYS_CLK_NS)

`endif

// [design/sra_pkg.sv]
package sra_pkg;

  // Protocol states of the register-access end.
  typedef enum logic [2:0] {
    SL_IDLE, SL_ADDR, SL_ACK, SL_WR, SL_RD, SL_RD_ACK, SL_IGNORE
  } slave_state_t;

  // Sequencer states of the bus-master end.
  typedef enum logic [2:0] {
    MS_IDLE, MS_HOLD, MS_START, MS_BIT, MS_STOP
  } master_state_t;

  // Byte-level commands accepted by the bus-master end.
  typedef enum logic [1:0] {
    CMD_START, CMD_STOP, CMD_WRITE, CMD_READ
  } cmd_t;

endpackage

// [design/sra_link_if.sv]
`timescale 1ns/1ps
`default_nettype none

interface sra_link_if;
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic s_sda_o;
  logic s_sda_oe;
  logic scl;
  logic sda;

  // Open-drain wires: a line is low only while some party enables a low drive.
  assign scl = !(m_scl_oe && !m_scl_o);
  assign sda = !((m_sda_oe && !m_sda_o) || (s_sda_oe && !s_sda_o));

  modport master (output m_scl_o, m_scl_oe, m_sda_o, m_sda_oe, input scl, sda);
  modport slave  (output s_sda_o, s_sda_oe, input scl, sda);
endinterface

`default_nettype wire

// [design/sra_slave.sv]
// Summary of operation
// - Answer address 4C to 4F by select pins.
// - Master changes data only while clock low.
// - Data change with clock high is start/stop.
// - Idle bus: both lines released high.
// - Start begins a new transaction.
// - First byte: seven address bits, direction bit.
// - Matching address acknowledged on ninth pulse.
// - No acknowledge on mismatch or index 0x0F.
// - All bytes shift most significant bit first.
// - Declined write byte leaves data line high.
// - Master no-acknowledge on read ends data.
// - Write: address, pointer byte, then data bytes.
// - Pointer increments after each stored byte.
// - Read: pointer write, then read address.
// - Pointer increments after each returned byte.
// - Stop ends the transaction.
// - Stop after pointer byte optional before read.
// - Repeated start opens a new address phase.
// - Master keeps clocking for consecutive bytes.
`include "sra_map.svh"
`timescale 1ns/1ps
`default_nettype none

module sra_slave (
  input  wire logic       i_sys_clk,
  input  wire logic       i_sys_rst,
  input  wire logic       i_link_clk,
  input  wire logic [1:0] i_slave_address_select_pins,
  output logic      [7:0] o_reg_addr,
  output logic      [7:0] o_reg_wdata,
  output logic            o_reg_wr,
  output logic            o_reg_rd,
  input  wire logic [7:0] i_reg_rdata,
  sra_link_if.slave       link
);
  import sra_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Link-domain state, clocked by i_link_clk, which samples the serial lines as data.

  typedef struct packed {
    logic         scl_m;
    logic         scl_s;
    logic         scl_p;
    logic         sda_m;
    logic         sda_s;
    logic         sda_p;
    logic [1:0]   sel_m;
    logic [1:0]   sel_s;
    logic         ack_m;
    logic         ack_s;
    logic         ack_p;
    slave_state_t state;
    logic [3:0]   bit_cnt;
    logic [7:0]   shreg;
    logic [7:0]   ptr;
    logic [7:0]   rdata;
    logic         rw;
    logic         have_ptr;
    logic         sda_oe;
    logic         req_tog;
    logic         req_we;
    logic [7:0]   req_addr;
    logic [7:0]   req_wdata;
  } link_st_t;

  // Register-side state, clocked by the system clock.
  typedef struct packed {
    logic       req_m;
    logic       req_s;
    logic       req_p;
    logic       fetch;
    logic       ack_tog;
    logic [7:0] rdata;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } sys_st_t;

  link_st_t   l_q;
  link_st_t   l_d;
  sys_st_t    s_q;
  sys_st_t    s_d;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_cond;
  logic       stop_cond;
  logic       byte_done;
  logic [6:0] own_addr;

  ////////////////////////////////////////////////////////////////////////////
  // Bus event decode on the synchronised lines.

  // The clock must be high in both samples, so a clock fall that
  // lands in the same sample as a data change is never taken for a stop.
  assign scl_rise   = l_q.scl_s & ~l_q.scl_p;
  assign scl_fall   = ~l_q.scl_s & l_q.scl_p;
  assign start_cond = l_q.scl_s & l_q.scl_p & l_q.sda_p & ~l_q.sda_s;
  assign stop_cond  = l_q.scl_s & l_q.scl_p & ~l_q.sda_p & l_q.sda_s;
  assign byte_done  = scl_fall && (l_q.bit_cnt == `SRA_BITS_PER_BYTE);
  assign own_addr   = `SRA_ADDR_BASE + {5'h00, l_q.sel_s};

  ////////////////////////////////////////////////////////////////////////////
  // Serial protocol engine. Bits are sampled on the clock's rising edge and
  // the data line is only changed after a falling edge.

  always_comb begin
    l_d       = l_q;
    l_d.scl_m = link.scl;
    l_d.scl_s = l_q.scl_m;
    l_d.scl_p = l_q.scl_s;
    l_d.sda_m = link.sda;
    l_d.sda_s = l_q.sda_m;
    l_d.sda_p = l_q.sda_s;
    l_d.sel_m = i_slave_address_select_pins;
    l_d.sel_s = l_q.sel_m;
    l_d.ack_m = s_q.ack_tog;
    l_d.ack_s = l_q.ack_m;
    l_d.ack_p = l_q.ack_s;
    // Returned register data is only copied once its handshake has settled.
    if (l_q.ack_s != l_q.ack_p) begin
      l_d.rdata = s_q.rdata;
    end
    if (start_cond) begin
      l_d.state    = SL_ADDR;
      l_d.bit_cnt  = 4'h0;
      l_d.have_ptr = 1'b0;
      l_d.sda_oe   = 1'b0;
    end else if (stop_cond) begin
      l_d.state  = SL_IDLE;
      l_d.sda_oe = 1'b0;
    end else begin
      unique case (l_q.state)
        SL_IDLE, SL_IGNORE: begin
          l_d.sda_oe = 1'b0;
        end
        SL_ADDR: begin
          if (scl_rise) begin
            l_d.shreg   = {l_q.shreg[6:0], l_q.sda_s};
            l_d.bit_cnt = l_q.bit_cnt + 4'h1;
          end else if (byte_done) begin
            l_d.rw = l_q.shreg[0];
            // A read of the never-acknowledged index is declined up front.
            if (l_q.shreg[7:1] == own_addr &&
                !(l_q.shreg[0] && l_q.ptr == `SRA_NOACK_INDEX)) begin
              l_d.state  = SL_ACK;
              l_d.sda_oe = 1'b1;
              if (l_q.shreg[0]) begin
                l_d.req_tog  = ~l_q.req_tog;
                l_d.req_we   = 1'b0;
                l_d.req_addr = l_q.ptr;
              end
            end else begin
              l_d.state = SL_IGNORE;
            end
          end
        end
        SL_ACK: begin
          // The acknowledge slot ends; a read drives its first bit at once.
          if (scl_fall) begin
            l_d.bit_cnt = 4'h0;
            if (l_q.rw) begin
              l_d.state  = SL_RD;
              l_d.shreg  = l_q.rdata;
              l_d.sda_oe = ~l_q.rdata[7];
            end else begin
              l_d.state  = SL_WR;
              l_d.sda_oe = 1'b0;
            end
          end
        end
        SL_WR: begin
          if (scl_rise) begin
            l_d.shreg   = {l_q.shreg[6:0], l_q.sda_s};
            l_d.bit_cnt = l_q.bit_cnt + 4'h1;
          end else if (byte_done) begin
            if (!l_q.have_ptr && l_q.shreg != `SRA_NOACK_INDEX) begin
              l_d.ptr      = l_q.shreg;
              l_d.have_ptr = 1'b1;
              l_d.state    = SL_ACK;
              l_d.sda_oe   = 1'b1;
            end else if (l_q.have_ptr && l_q.ptr != `SRA_NOACK_INDEX) begin
              l_d.req_tog   = ~l_q.req_tog;
              l_d.req_we    = 1'b1;
              l_d.req_addr  = l_q.ptr;
              l_d.req_wdata = l_q.shreg;
              l_d.ptr       = l_q.ptr + 8'h01;
              l_d.state     = SL_ACK;
              l_d.sda_oe    = 1'b1;
            end else begin
              l_d.state  = SL_IGNORE;
              l_d.sda_oe = 1'b0;
            end
          end
        end
        SL_RD: begin
          if (scl_rise) begin
            l_d.bit_cnt = l_q.bit_cnt + 4'h1;
          end else if (byte_done) begin
            l_d.sda_oe = 1'b0;
            l_d.ptr    = l_q.ptr + 8'h01;
            l_d.state  = SL_RD_ACK;
          end else if (scl_fall) begin
            l_d.shreg  = {l_q.shreg[6:0], 1'b0};
            l_d.sda_oe = ~l_q.shreg[6];
          end
        end
        SL_RD_ACK: begin
          if (scl_rise) begin
            if (!l_q.sda_s) begin
              // Fetch the next register while the master holds its acknowledge.
              l_d.req_tog  = ~l_q.req_tog;
              l_d.req_we   = 1'b0;
              l_d.req_addr = l_q.ptr;
              l_d.state    = SL_ACK;
            end else begin
              l_d.state = SL_IGNORE;
            end
          end
        end
        default: begin
          l_d.state  = SL_IGNORE;
          l_d.sda_oe = 1'b0;
        end
      endcase
    end
  end

  // The state enum codes SL_IDLE as zero, so an all-zero reset is idle.
  always_ff @(posedge i_link_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      l_q <= '0;
    end else begin
      l_q <= l_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register-side handshake. The link holds address and data stable from its
  // toggle until the next request, which comes a byte time later at the
  // earliest, so the words need no synchroniser of their own.

  always_comb begin
    s_d       = s_q;
    s_d.req_m = l_q.req_tog;
    s_d.req_s = s_q.req_m;
    s_d.req_p = s_q.req_s;
    s_d.wr    = 1'b0;
    s_d.rd    = 1'b0;
    // The fetch flag trails the read strobe by one cycle, so the register
    // file may answer with registered data.
    s_d.fetch = s_q.rd;
    if (s_q.req_s != s_q.req_p) begin
      s_d.addr  = l_q.req_addr;
      s_d.wdata = l_q.req_wdata;
      if (l_q.req_we) begin
        s_d.wr      = 1'b1;
        s_d.ack_tog = ~s_q.ack_tog;
      end else begin
        s_d.rd = 1'b1;
      end
    end
    // Read data is taken one cycle after the read strobe.
    if (s_q.fetch) begin
      s_d.rdata   = i_reg_rdata;
      s_d.ack_tog = ~s_q.ack_tog;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs. The data pin is open drain: only a low level is ever driven.

  assign o_reg_addr    = s_q.addr;
  assign o_reg_wdata   = s_q.wdata;
  assign o_reg_wr      = s_q.wr;
  assign o_reg_rd      = s_q.rd;
  assign link.s_sda_o  = 1'b0;
  assign link.s_sda_oe = l_q.sda_oe;

endmodule

`default_nettype wire

// [design/sra_master.sv]
`include "sra_map.svh"
`timescale 1ns/1ps
`default_nettype none

module sra_master #(
  parameter int QTR_CYCLES = `SRA_QTR_CYCLES
) (
  input  wire logic          i_sys_clk,
  input  wire logic          i_sys_rst,
  input  wire logic          i_cmd_valid,
  input  wire sra_pkg::cmd_t i_cmd,
  input  wire logic    [7:0] i_cmd_data,
  input  wire logic          i_cmd_last,
  output logic               o_cmd_ready,
  output logic               o_rsp_valid,
  output logic         [7:0] o_rsp_data,
  output logic               o_rsp_nack,
  sra_link_if.master         link
);
  import sra_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State of the bus sequencer. The serial clock is made here by dividing
  // the system clock, so the whole end runs in one domain.

  typedef struct packed {
    master_state_t state;
    logic [15:0]   qcnt;
    logic [1:0]    q;
    logic [3:0]    bit_cnt;
    logic [7:0]    shreg;
    logic          rd;
    logic          last;
    logic          scl_oe;
    logic          sda_oe;
    logic          sda_m;
    logic          sda_s;
    logic          ready;
    logic          rsp_valid;
    logic [7:0]    rsp_data;
    logic          nack;
  } master_st_t;

  master_st_t m_q;
  master_st_t m_d;
  logic       tick;

  assign tick = (m_q.qcnt == 16'(QTR_CYCLES - 1));

  ////////////////////////////////////////////////////////////////////////////
  // Each bus step spans four quarters; the action listed for a quarter is
  // taken at its end. Outside start and stop, data moves only while the clock is held low.

  always_comb begin
    m_d           = m_q;
    m_d.sda_m     = link.sda;
    m_d.sda_s     = m_q.sda_m;
    m_d.rsp_valid = 1'b0;
    if (m_q.state == MS_START || m_q.state == MS_BIT || m_q.state == MS_STOP) begin
      m_d.qcnt = tick ? 16'h0000 : m_q.qcnt + 16'h0001;
      if (tick) begin
        m_d.q = m_q.q + 2'h1;
      end
    end
    unique case (m_q.state)
      MS_IDLE, MS_HOLD: begin
        if (i_cmd_valid) begin
          m_d.ready = 1'b0;
          m_d.qcnt  = 16'h0000;
          m_d.q     = 2'h0;
          unique case (i_cmd)
            CMD_START: m_d.state = MS_START;
            CMD_STOP: begin
              // With the bus already free a stop would look like a start.
              if (m_q.state == MS_HOLD) begin
                m_d.state = MS_STOP;
              end else begin
                m_d.ready     = 1'b1;
                m_d.rsp_valid = 1'b1;
              end
            end
            CMD_WRITE, CMD_READ: begin
              m_d.state   = MS_BIT;
              m_d.rd      = (i_cmd == CMD_READ);
              m_d.last    = i_cmd_last;
              m_d.shreg   = i_cmd_data;
              m_d.bit_cnt = 4'h0;
            end
          endcase
        end
      end
      MS_START: begin
        if (tick) begin
          unique case (m_q.q)
            2'h0: m_d.sda_oe = 1'b0;
            2'h1: m_d.scl_oe = 1'b0;
            2'h2: m_d.sda_oe = 1'b1;
            2'h3: begin
              m_d.scl_oe    = 1'b1;
              m_d.state     = MS_HOLD;
              m_d.ready     = 1'b1;
              m_d.rsp_valid = 1'b1;
            end
          endcase
        end
      end
      MS_BIT: begin
        if (tick) begin
          unique case (m_q.q)
            2'h0: begin
              if (m_q.bit_cnt != `SRA_BITS_PER_BYTE) begin
                m_d.sda_oe = m_q.rd ? 1'b0 : ~m_q.shreg[7];
              end else begin
                m_d.sda_oe = m_q.rd ? ~m_q.last : 1'b0;
              end
            end
            2'h1: m_d.scl_oe = 1'b0;
            2'h2: begin
              if (m_q.bit_cnt != `SRA_BITS_PER_BYTE) begin
                m_d.shreg = {m_q.shreg[6:0], m_q.sda_s};
              end else begin
                m_d.nack = m_q.sda_s;
              end
            end
            2'h3: begin
              // The data line is left as it is so it never moves with SCL.
              m_d.scl_oe = 1'b1;
              if (m_q.bit_cnt == `SRA_BITS_PER_BYTE) begin
                m_d.state     = MS_HOLD;
                m_d.ready     = 1'b1;
                m_d.rsp_valid = 1'b1;
                m_d.rsp_data  = m_q.shreg;
              end else begin
                m_d.bit_cnt = m_q.bit_cnt + 4'h1;
              end
            end
          endcase
        end
      end
      MS_STOP: begin
        if (tick) begin
          unique case (m_q.q)
            2'h0: m_d.sda_oe = 1'b1;
            2'h1: m_d.scl_oe = 1'b0;
            2'h2: m_d.sda_oe = 1'b0;
            2'h3: begin
              m_d.state     = MS_IDLE;
              m_d.ready     = 1'b1;
              m_d.rsp_valid = 1'b1;
            end
          endcase
        end
      end
      default: begin
        m_d.state = MS_IDLE;
      end
    endcase
  end

  // Reset leaves both lines released and the command port ready.
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      m_q       <= '0;
      m_q.ready <= 1'b1;
    end else begin
      m_q <= m_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs; both pins are open drain.

  assign o_cmd_ready   = m_q.ready;
  assign o_rsp_valid   = m_q.rsp_valid;
  assign o_rsp_data    = m_q.rsp_data;
  assign o_rsp_nack    = m_q.nack;
  assign link.m_scl_o  = 1'b0;
  assign link.m_scl_oe = m_q.scl_oe;
  assign link.m_sda_o  = 1'b0;
  assign link.m_sda_oe = m_q.sda_oe;

endmodule

`default_nettype wire

// [test/sra_link_props.sv]
`timescale 1ns/1ps
`default_nettype none

module sra_link_props (
  input  wire logic       i_sys_clk,
  input  wire logic       i_sys_rst,
  input  wire logic [1:0] i_slave_address_select_pins,
  input  wire logic       m_scl_oe,
  input  wire logic       m_sda_oe,
  input  wire logic       s_sda_oe,
  input  wire logic       scl,
  input  wire logic       sda
);
  // Write acks are held for half a serial period plus the slave's resync, well under this.
  // A read-address ack may run on into zero data bits, so only write acks are timed.
  localparam int REL_MAX = 400;

  logic       scl_q, sda_q, first_q, rd_q, ign_q, idle_q;
  logic       start_w, stop_w, rise_w, ack_w;
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  logic [6:0] own;

  ////////////////////////////////////////////////////////////////////////////////
  // Line events, oversampled on the host clock.
  always_comb begin
    own     = 7'h4C + {5'h00, i_slave_address_select_pins};
    start_w = scl && scl_q && sda_q && !sda;
    stop_w  = scl && scl_q && !sda_q && sda;
    rise_w  = scl && !scl_q;
    ack_w   = rise_w && cnt_q == 4'h8;
  end

  // Byte framer; the clock pulse of a stop or restart bumps the count, which the start clears.
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      scl_q   <= 1'b1;
      sda_q   <= 1'b1;
      cnt_q   <= 4'h0;
      sh_q    <= 8'h00;
      first_q <= 1'b0;
      rd_q    <= 1'b0;
      ign_q   <= 1'b0;
      idle_q  <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (start_w) begin
        cnt_q   <= 4'h0;
        first_q <= 1'b1;
        ign_q   <= 1'b0;
        idle_q  <= 1'b0;
      end else if (stop_w) begin
        idle_q <= 1'b1;
      end else if (ack_w) begin
        cnt_q   <= 4'h0;
        first_q <= 1'b0;
        ign_q   <= ign_q | sda;
        rd_q    <= first_q ? sh_q[0] : rd_q;
      end else if (rise_w) begin
        cnt_q <= cnt_q + 4'h1;
        sh_q  <= {sh_q[6:0], sda};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Properties of the wire, all on the host clock.
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);

  property p_own_ack;
    ack_w && first_q && sh_q == {own, 1'b0} |-> !sda && s_sda_oe;
  endproperty
  a_own_ack: assert property (p_own_ack) else $error("own write address not acked");
  property p_foreign_nack;
    ack_w && first_q && sh_q[7:1] != own |-> sda;
  endproperty
  a_foreign_nack: assert property (p_foreign_nack) else $error("foreign address acked");
  property p_ignore_quiet;
    ign_q |-> !s_sda_oe;
  endproperty
  a_ignore_quiet: assert property (p_ignore_quiet) else $error("slave drives after nack");
  property p_slave_scl_low;
    $changed(s_sda_oe) |-> !scl;
  endproperty
  a_slave_scl_low: assert property (p_slave_scl_low) else $error("slave data moved at high clock");
  property p_master_mid_byte;
    scl && cnt_q > 4'h1 |-> $stable(m_sda_oe);
  endproperty
  a_master_mid_byte: assert property (p_master_mid_byte) else $error("master data moved at high clock");
  property p_stop_idle;
    stop_w |=> (scl && sda) [*8];
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("bus not idle after stop");
  property p_idle_quiet;
    idle_q |-> !m_scl_oe && !s_sda_oe;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("line pulled while idle");
  property p_ack_release;
    ack_w && s_sda_oe && !(first_q ? sh_q[0] : rd_q) |-> ##[1:REL_MAX] !s_sda_oe;
  endproperty
  a_ack_release: assert property (p_ack_release) else $error("ack not released");
  property p_write_free;
    rise_w && !first_q && !rd_q && cnt_q != 4'h8 |-> !s_sda_oe;
  endproperty
  a_write_free: assert property (p_write_free) else $error("slave drives write data");
  property p_read_ack_slot;
    ack_w && rd_q && !first_q |-> !s_sda_oe;
  endproperty
  a_read_ack_slot: assert property (p_read_ack_slot) else $error("slave drives master ack");

  c_start: cover property (start_w);
  c_nack: cover property (ack_w && sda);
  c_read: cover property (ack_w && rd_q && !first_q && !sda);
endmodule

`default_nettype wire

// [test/serial_register_access_slave_tb.sv]
`timescale 1ns/1ps
`default_nettype none

module serial_register_access_slave_tb;
  import sra_pkg::*;

  localparam int QTR = 60;
  localparam int LIM = 4000;

  logic        i_sys_clk  = 1'b0;
  logic        i_link_clk = 1'b0;
  logic        i_sys_rst  = 1'b1;
  logic [1:0]  sel        = 2'h0;
  logic        cmd_valid  = 1'b0;
  cmd_t        cmd        = CMD_STOP;
  logic [7:0]  cmd_data   = 8'h00;
  logic        cmd_last   = 1'b0;
  logic [7:0]  reg_rdata  = 8'h00;
  logic        cmd_ready, rsp_valid, rsp_nack, reg_wr, reg_rd;
  logic [7:0]  rsp_data, reg_addr, reg_wdata, ptr;
  logic [7:0]  mem [256];
  logic [7:0]  gold [256];
  logic [31:0] seed = 32'h0000_B768;
  logic [10:0] q_rsp [$];
  logic [15:0] q_reg [$];
  logic [7:0]  q_wire [$];
  logic [7:0]  wbyte = 8'h00;
  int          bitn = 0;
  int          n_mismatch = 0;
  int          n_compared = 0;

  always #12.5 i_sys_clk = ~i_sys_clk;
  always #80 i_link_clk = ~i_link_clk;

  sra_link_if sra_link_if_inst ();
  sra_master #(.QTR_CYCLES(QTR)) sra_master_inst (
    .i_sys_clk (i_sys_clk), .i_sys_rst (i_sys_rst), .i_cmd_valid (cmd_valid), .i_cmd (cmd),
    .i_cmd_data (cmd_data), .i_cmd_last (cmd_last), .o_cmd_ready (cmd_ready), .o_rsp_valid (rsp_valid),
    .o_rsp_data (rsp_data), .o_rsp_nack (rsp_nack), .link (sra_link_if_inst.master));
  sra_slave sra_slave_inst (
    .i_sys_clk (i_sys_clk), .i_sys_rst (i_sys_rst), .i_link_clk (i_link_clk),
    .i_slave_address_select_pins (sel), .o_reg_addr (reg_addr), .o_reg_wdata (reg_wdata),
    .o_reg_wr (reg_wr), .o_reg_rd (reg_rd), .i_reg_rdata (reg_rdata), .link (sra_link_if_inst.slave));
  sra_link_props sra_link_props_inst (
    .i_sys_clk (i_sys_clk), .i_sys_rst (i_sys_rst), .i_slave_address_select_pins (sel),
    .m_scl_oe (sra_link_if_inst.m_scl_oe), .m_sda_oe (sra_link_if_inst.m_sda_oe),
    .s_sda_oe (sra_link_if_inst.s_sda_oe), .scl (sra_link_if_inst.scl), .sda (sra_link_if_inst.sda));

  ////////////////////////////////////////////////////////////////////////////////
  // Xorshift source; only its low byte is handed out.
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction

  task automatic final_report();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic tally(input string what, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s exp %h got %h", what, e, g);
    end
  endtask

  task automatic cmp_rsp(input logic [8:0] e, input logic [8:0] g);
    tally("response", {7'h00, e}, {7'h00, g});
  endtask
  task automatic cmp_reg(input logic [15:0] e, input logic [15:0] g);
    tally("reg_write", e, g);
  endtask
  task automatic cmp_wire(input logic [7:0] e, input logic [7:0] g);
    tally("wire_byte", {8'h00, e}, {8'h00, g});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Register file behind the device end; read data is ready one cycle after the read strobe.
  always @(posedge i_sys_clk) begin
    if (reg_wr === 1'b1) begin
      mem[reg_addr] <= reg_wdata;
    end
    if (reg_rd === 1'b1) begin
      reg_rdata <= mem[reg_addr];
    end
  end

  // Watchers pop the oldest note; an unexpected store is compared against its own inverse, a response against its flipped nack.
  always @(posedge i_sys_clk) begin
    logic [10:0] e;
    if (rsp_valid === 1'b1) begin
      e = (q_rsp.size() != 0) ? q_rsp.pop_front() : {2'b01, ~rsp_nack, rsp_data};
      if (e[10:9] == 2'b01) cmp_rsp(e[8:0], {rsp_nack, rsp_data});
      if (e[10:9] == 2'b10) cmp_rsp({1'b0, e[7:0]}, {1'b0, rsp_data});
    end
    if (reg_wr === 1'b1) begin
      cmp_reg((q_reg.size() != 0) ? q_reg.pop_front() : ~{reg_addr, reg_wdata}, {reg_addr, reg_wdata});
    end
  end

  // A start clears the bit count; the ninth pulse closes a byte, first bit on top.
  always @(negedge sra_link_if_inst.sda) begin
    if (sra_link_if_inst.scl === 1'b1) begin
      bitn = 0;
    end
  end
  always @(posedge sra_link_if_inst.scl) begin
    if (bitn < 8) begin
      wbyte = {wbyte[6:0], sra_link_if_inst.sda};
      bitn = bitn + 1;
    end else begin
      cmp_wire((q_wire.size() != 0) ? q_wire.pop_front() : ~wbyte, wbyte);
      bitn = 0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Drivers: change inputs 2 ns after an edge and hold the request through the taking edge.
  task automatic wait_ready();
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < LIM) begin
      @(posedge i_sys_clk);
      #2;
      n++;
    end
    if (n >= LIM) begin
      n_mismatch++;
      $display("[ERR] cmd_ready exp 1 got %b", cmd_ready);
      final_report();
    end
  endtask

  task automatic send(input cmd_t c, input logic [7:0] d, input logic l, input logic [10:0] e);
    wait_ready();
    q_rsp.push_back(e);
    cmd_valid = 1'b1;
    cmd = c;
    cmd_data = d;
    cmd_last = l;
    @(posedge i_sys_clk);
    #2;
    cmd_valid = 1'b0;
  endtask

  task automatic wr(input logic [7:0] d, input logic nack);
    q_wire.push_back(d);
    send(CMD_WRITE, d, 1'b0, {2'b01, nack, d});
  endtask

  task automatic wd(input logic [7:0] d);
    q_reg.push_back({ptr, d});
    gold[ptr] = d;
    ptr = ptr + 8'h01;
    wr(d, 1'b0);
  endtask

  task automatic rd(input logic last);
    q_wire.push_back(gold[ptr]);
    send(CMD_READ, 8'h00, last, {2'b10, 1'b0, gold[ptr]});
    ptr = ptr + 8'h01;
  endtask

  initial begin
    for (int i = 0; i < 256; i++) begin
      gold[i] = rnd();
      mem[i] = gold[i];
    end
    repeat (16) @(posedge i_sys_clk);
    #2;
    i_sys_rst = 1'b0;
    repeat (40) @(posedge i_sys_clk);
    #2;
    // Burst from 0x0B: four stores, then the fifth meets index 0x0F and is refused.
    send(CMD_START, 8'h00, 1'b0, 11'h000);
    wr(8'h98, 1'b0);
    ptr = 8'h0B;
    wr(ptr, 1'b0);
    repeat (4) wd(rnd());
    wr(rnd(), 1'b1);
    // The pointer now rests on 0x0F, so a read address is refused as well.
    send(CMD_START, 8'h00, 1'b0, 11'h000);
    wr(8'h99, 1'b1);
    send(CMD_STOP, 8'h00, 1'b0, 11'h000);
    $display("test burst_write done");
    // Pointer set, repeated start, then three reads with the last one refused by the master.
    sel = 2'h1;
    send(CMD_START, 8'h00, 1'b0, 11'h000);
    wr(8'h9A, 1'b0);
    ptr = 8'h0C;
    wr(ptr, 1'b0);
    send(CMD_START, 8'h00, 1'b0, 11'h000);
    wr(8'h9B, 1'b0);
    rd(1'b0);
    rd(1'b0);
    rd(1'b1);
    send(CMD_STOP, 8'h00, 1'b0, 11'h000);
    $display("test burst_read done");
    // Every select value: own address stores, the neighbour's address is ignored.
    for (int s = 0; s < 4; s++) begin
      sel = s[1:0];
      send(CMD_START, 8'h00, 1'b0, 11'h000);
      wr({7'h4C + 7'(s), 1'b0}, 1'b0);
      ptr = rnd();
      if (ptr == 8'h0F) begin
        ptr = 8'h10;
      end
      wr(ptr, 1'b0);
      wd(rnd());
      send(CMD_START, 8'h00, 1'b0, 11'h000);
      wr({7'h4C + 7'(s + 1), 1'b0}, 1'b1);
      wr(rnd(), 1'b1);
      send(CMD_STOP, 8'h00, 1'b0, 11'h000);
    end
    $display("test address_select done");
    wait_ready();
    repeat (10) @(posedge i_sys_clk);
    if (q_rsp.size() + q_reg.size() + q_wire.size() != 0) begin
      n_mismatch++;
      $display("[ERR] pending exp 0 got %0d", q_rsp.size() + q_reg.size() + q_wire.size());
    end
    final_report();
  end
endmodule

`default_nettype wire
